// ==== spbc_pd_source.sv ====
// photodiode current source standing in for the optical front end
`timescale 1ns/1ps
`default_nettype none
module spbc_pd_source
	import spbc_pkg::*;
#(
	parameter logic [7:0] BASE = 8'h10
) (
	// currents, one fixed level per channel and sensor
	output var spbc_pd_t pdMaster,
	output var spbc_pd_t pdCompA,
	output var spbc_pd_t pdCompB
);
	// ============================================================
	// steady light, each channel distinct so misrouting shows
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			pdMaster.cur[c] = BASE + 8'(c);
			pdCompA.cur[c] = BASE + 8'(6 + c);
			pdCompB.cur[c] = BASE + 8'(12 + c);
		end
	end
endmodule // spbc_pd_source
`default_nettype wire

// ==== spbc_period_timer.sv ====
// integration period timer
`timescale 1ns/1ps
`default_nettype none
module spbc_period_timer
	import spbc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// period in cycles, held stable through a period
	input wire logic [31:0] periodCyc,
	// end of period pulse
	output logic periodEnd
);
	logic [31:0] count_q;
	logic [31:0] count_d;
	wire logic [31:0] lastCount = periodCyc - 32'h1;

	assign periodEnd = (count_q >= lastCount);
	assign count_d = periodEnd ? 32'h0 : count_q + 32'h1;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			count_q <= 32'h0;
		end else begin
			count_q <= count_d;
		end
	end

	// ============================================================
	// checks
	property p_period_len;
		@(posedge ref_clk) disable iff (!rst_b)
		periodEnd |=> (count_q == 32'h0) && !periodEnd;
	endproperty
	a_period_len: assert property (p_period_len) else $error("period restart wrong");
endmodule // spbc_period_timer
`default_nettype wire

// ==== spbc_pkg.sv ====
// constants and types for the spectral bank conversion block
`default_nettype none
package spbc_pkg;
	// ============================================================
	// sizes
	localparam int ADC_W = 16;
	localparam int CUR_W = 8;
	localparam int NCH = 6;
	localparam int NSENS = 3;
	localparam int NWORDS = NSENS * NCH;
	// ============================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PERIOD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_DATA0 = 8'h10;
	localparam logic [7:0] OFF_DATA_LAST = 8'h54;
	// ============================================================
	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_INTEN_BIT = 2;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_BANK_BIT = 1;
	localparam int STAT_MODE_LSB = 2;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_IT_NS = 2800000;
	localparam int MIN_IT_CYC = (MIN_IT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ============================================================
	// reset values and count full scale
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic INTEN_RST = 1'b0;
	localparam logic [31:0] PERIOD_RST = 32'(MIN_IT_CYC);
	localparam logic [ADC_W-1:0] CNT_MAX = 16'hffff;
	// ============================================================
	// bank channel masks, bit 0 is the shortest wavelength
	localparam logic [NCH-1:0] MASK_MAIN_B0 = 6'h1e;
	localparam logic [NCH-1:0] MASK_MAIN_B1 = 6'h2d;
	localparam logic [NCH-1:0] MASK_COMP_B0 = 6'h17;
	localparam logic [NCH-1:0] MASK_COMP_B1 = 6'h2b;
	// ============================================================
	// types
	typedef enum logic [1:0] {
		SPBC_MODE0 = 2'b00,
		SPBC_MODE1 = 2'b01,
		SPBC_MODE2 = 2'b10
	} spbc_mode_t;
	typedef enum logic {
		SPBC_BANK_FIRST = 1'b0,
		SPBC_BANK_SECOND = 1'b1
	} spbc_bank_t;
	typedef struct packed {
		logic [NCH-1:0][CUR_W-1:0] cur;
	} spbc_pd_t;
	typedef struct packed {
		logic [NCH-1:0][ADC_W-1:0] cnt;
	} spbc_res_t;
endpackage
`default_nettype wire

// ==== spbc_sensor.sv ====
// one six channel sensor: integrate, bank mask, double buffer
`timescale 1ns/1ps
`default_nettype none
module spbc_sensor
	import spbc_pkg::*;
#(
	parameter bit COMPANION = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// photodiode currents
	input wire spbc_pd_t pd,
	// sequencing
	input wire logic bankSel,
	input wire logic firstBank,
	input wire logic periodEnd,
	input wire logic commit,
	// results
	output spbc_res_t result
);
	logic [NCH-1:0][ADC_W-1:0] acc_q;
	logic [NCH-1:0][ADC_W-1:0] acc_d;
	logic [NCH-1:0][ADC_W-1:0] stage_q;
	logic [NCH-1:0][ADC_W-1:0] stage_d;
	logic [NCH-1:0][ADC_W-1:0] res_q;
	wire logic [NCH-1:0] mainMask = bankSel ? MASK_MAIN_B1 : MASK_MAIN_B0;
	wire logic [NCH-1:0] compMask = bankSel ? MASK_COMP_B1 : MASK_COMP_B0;
	wire logic [NCH-1:0] mask = COMPANION ? compMask : mainMask;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		wire logic [ADC_W:0] sum = {1'b0, acc_q[c]} + (ADC_W+1)'(pd.cur[c]);
		wire logic [ADC_W-1:0] sat = sum[ADC_W] ? CNT_MAX : sum[ADC_W-1:0];
		assign acc_d[c] = periodEnd ? '0 : (mask[c] ? sat : acc_q[c]);
		// the closing cycle's current counts too, so a period of P cycles integrates P samples
		assign stage_d[c] = mask[c] ? sat : (firstBank ? '0 : stage_q[c]);
	end

	assign result.cnt = res_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_q <= '0;
			stage_q <= '0;
			res_q <= '0;
		end else begin
			acc_q <= acc_d;
			if (periodEnd) begin
				stage_q <= stage_d;
			end
			if (commit) begin
				res_q <= stage_d;
			end
		end
	end

	// ============================================================
	// checks
	property p_res_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		!commit |=> $stable(res_q);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("results moved outside commit");
	property p_sat;
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_q[1] == CNT_MAX) && mask[1] && !periodEnd |=> acc_q[1] == CNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("count did not saturate");
endmodule // spbc_sensor
`default_nettype wire

// ==== spbc_top.sv ====
// spectral bank conversion: sequencer, apb registers, three sensors
`timescale 1ns/1ps
`default_nettype none
module spbc_top
	import spbc_pkg::*;
#(
	parameter int unsigned MIN_PERIOD_CYC = MIN_IT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// photodiode currents
	input wire spbc_pd_t pdMaster,
	input wire spbc_pd_t pdCompA,
	input wire spbc_pd_t pdCompB,
	// alert
	output logic intAlert_b
);
	// ============================================================
	// state
	logic [1:0] bankMode_q;
	logic intEn_q;
	logic [31:0] period_q;
	spbc_mode_t activeMode_q;
	logic [31:0] activePeriod_q;
	spbc_bank_t bank_q;
	spbc_bank_t bank_d;
	logic ready_q;
	logic intAlertB_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic periodEnd;
	spbc_res_t resMaster;
	spbc_res_t resCompA;
	spbc_res_t resCompB;

	// ============================================================
	// apb decode
	wire logic setupPh = psel && !penable;
	wire logic accessPh = psel && penable;
	wire logic wrEn = accessPh && pwrite;
	wire logic hitCtrl = (paddr == OFF_CTRL);
	wire logic hitPeriod = (paddr == OFF_PERIOD);
	wire logic hitStatus = (paddr == OFF_STATUS);
	wire logic hitData = (paddr >= OFF_DATA0) && (paddr <= OFF_DATA_LAST)
		&& (paddr[1:0] == 2'b00);
	wire logic mapped = hitCtrl || hitPeriod || hitStatus || hitData;
	wire logic [7:0] dataOff = paddr - OFF_DATA0;
	wire logic [4:0] dataIdx = dataOff[6:2];
	wire logic dataRead = accessPh && !pwrite && hitData;

	// ============================================================
	// sequencing
	wire logic needTwo = (activeMode_q == SPBC_MODE2);
	wire logic commit = periodEnd && (!needTwo || (bank_q == SPBC_BANK_SECOND));
	wire logic cycleStart = commit;
	wire logic firstBank = (bank_q == SPBC_BANK_FIRST);
	wire logic bankSel = needTwo ? (bank_q == SPBC_BANK_SECOND) : activeMode_q[0];
	wire logic [1:0] modeIn = (bankMode_q == 2'b11) ? SPBC_MODE2 : bankMode_q;
	wire logic [31:0] minPeriod = 32'(MIN_PERIOD_CYC);
	wire logic [31:0] periodIn = (period_q < minPeriod) ? minPeriod : period_q;

	always_comb begin
		bank_d = bank_q;
		if (periodEnd) begin
			unique case (bank_q)
				SPBC_BANK_FIRST: begin
					bank_d = needTwo ? SPBC_BANK_SECOND : SPBC_BANK_FIRST;
				end
				SPBC_BANK_SECOND: begin
					bank_d = SPBC_BANK_FIRST;
				end
			endcase
		end
	end

	// ============================================================
	// ready and alert
	wire logic ready_d = commit || (ready_q && !dataRead);
	wire logic alertB_d = !(intEn_q && ready_d);

	// ============================================================
	// read data
	wire logic [NWORDS-1:0][ADC_W-1:0] allCnt = {resCompB.cnt, resCompA.cnt, resMaster.cnt};
	wire logic [31:0] ctrlWord = {29'h0, intEn_q, bankMode_q};
	wire logic [31:0] statWord = {28'h0, activeMode_q, bank_q, ready_q};
	wire logic [31:0] dataWord = {16'h0, allCnt[dataIdx]};
	wire logic [31:0] rdData = hitCtrl ? ctrlWord :
		hitPeriod ? period_q :
		hitStatus ? statWord :
		hitData ? dataWord : 32'h0;

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q;
	assign intAlert_b = intAlertB_q;

	// ============================================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bankMode_q <= MODE_RST;
			intEn_q <= INTEN_RST;
			period_q <= PERIOD_RST;
		end else if (wrEn && hitCtrl) begin
			bankMode_q <= pwdata[CTRL_MODE_LSB +: 2];
			intEn_q <= pwdata[CTRL_INTEN_BIT];
		end else if (wrEn && hitPeriod) begin
			period_q <= pwdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			activeMode_q <= SPBC_MODE0;
			activePeriod_q <= 32'(MIN_PERIOD_CYC);
		end else if (cycleStart) begin
			activeMode_q <= spbc_mode_t'(modeIn);
			activePeriod_q <= periodIn;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bank_q <= SPBC_BANK_FIRST;
			ready_q <= 1'b0;
			intAlertB_q <= 1'b1;
		end else begin
			bank_q <= bank_d;
			ready_q <= ready_d;
			intAlertB_q <= alertB_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (setupPh) begin
			prdata_q <= pwrite ? 32'h0 : rdData;
			pslverr_q <= !mapped;
		end
	end

	// ============================================================
	// timer and sensors
	spbc_period_timer u_timer (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.periodCyc(activePeriod_q),
		.periodEnd(periodEnd)
	);

	// master and companions share one bank selection
	spbc_sensor #(.COMPANION(1'b0)) u_master (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pd(pdMaster),
		.bankSel(bankSel),
		.firstBank(firstBank),
		.periodEnd(periodEnd),
		.commit(commit),
		.result(resMaster)
	);

	spbc_sensor #(.COMPANION(1'b1)) u_comp_a (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pd(pdCompA),
		.bankSel(bankSel),
		.firstBank(firstBank),
		.periodEnd(periodEnd),
		.commit(commit),
		.result(resCompA)
	);

	spbc_sensor #(.COMPANION(1'b1)) u_comp_b (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pd(pdCompB),
		.bankSel(bankSel),
		.firstBank(firstBank),
		.periodEnd(periodEnd),
		.commit(commit),
		.result(resCompB)
	);

	// ============================================================
	// checks
	sequence s_commit_mode(logic [1:0] m);
		commit && (activeMode_q == m);
	endsequence

	property p_mode0_main;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit_mode(SPBC_MODE0) |=> (resMaster.cnt[0] == '0) && (resMaster.cnt[5] == '0);
	endproperty
	a_mode0_main: assert property (p_mode0_main) else $error("mode 0 master zeros wrong");

	property p_mode0_comp;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit_mode(SPBC_MODE0) |=> (resCompA.cnt[3] == '0) && (resCompB.cnt[5] == '0);
	endproperty
	a_mode0_comp: assert property (p_mode0_comp) else $error("mode 0 companion zeros wrong");

	property p_mode1_main;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit_mode(SPBC_MODE1) |=> (resMaster.cnt[1] == '0) && (resMaster.cnt[4] == '0);
	endproperty
	a_mode1_main: assert property (p_mode1_main) else $error("mode 1 master zeros wrong");

	property p_mode1_comp;
		@(posedge ref_clk) disable iff (!rst_b)
		s_commit_mode(SPBC_MODE1) |=> (resCompA.cnt[2] == '0) && (resCompB.cnt[4] == '0);
	endproperty
	a_mode1_comp: assert property (p_mode1_comp) else $error("mode 1 companion zeros wrong");

	property p_mode2_two;
		@(posedge ref_clk) disable iff (!rst_b)
		periodEnd && needTwo && firstBank |-> !commit ##1 (bank_q == SPBC_BANK_SECOND);
	endproperty
	a_mode2_two: assert property (p_mode2_two) else $error("mode 2 committed after one bank");

	property p_alert_set;
		@(posedge ref_clk) disable iff (!rst_b)
		commit && intEn_q |=> !intAlert_b && ready_q;
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("alert not raised on ready");

	property p_alert_rel;
		@(posedge ref_clk) disable iff (!rst_b)
		dataRead && !commit |=> intAlert_b && !ready_q;
	endproperty
	a_alert_rel: assert property (p_alert_rel) else $error("data read did not release alert");

	property p_apply_at_start;
		@(posedge ref_clk) disable iff (!rst_b)
		!cycleStart |=> $stable(activeMode_q) && $stable(activePeriod_q);
	endproperty
	a_apply_at_start: assert property (p_apply_at_start) else $error("setting changed mid cycle");

	property p_min_period;
		@(posedge ref_clk) disable iff (!rst_b)
		cycleStart |=> activePeriod_q >= minPeriod;
	endproperty
	a_min_period: assert property (p_min_period) else $error("period below minimum");
endmodule // spbc_top
`default_nettype wire

// ==== spbc_top_test.sv ====
// self-checking testbench for the spectral bank conversion block
`timescale 1ns/1ps
`default_nettype none
module spbc_top_test;
	import spbc_pkg::*;
	// ============================================================
	// signals
	logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, intAlert_b;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic erv;
	spbc_pd_t pdMaster, pdCompA, pdCompB;
	int mismatches, samplesChecked, n;
	// ============================================================
	// design and light source
	spbc_top #(.MIN_PERIOD_CYC(40)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pdMaster(pdMaster), .pdCompA(pdCompA),
		.pdCompB(pdCompB), .intAlert_b(intAlert_b));
	spbc_pd_source #(.BASE(8'h10)) src (.pdMaster(pdMaster), .pdCompA(pdCompA),
		.pdCompB(pdCompB));
	always #5 ref_clk = ~ref_clk;
	// ============================================================
	// checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ============================================================
	// apb transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ============================================================
	// expected count, masks written from the bank tables
	function automatic logic [31:0] expv(int s, int c, int m, int p);
		logic [5:0] msk;
		logic [31:0] v;
		msk = (m == 2) ? 6'h3f : (s == 0) ? (m == 0 ? 6'h1e : 6'h2d) : (m == 0 ? 6'h17 : 6'h2b);
		v = 32'((16 + s * 6 + c) * p);
		if (v > 32'hffff) v = 32'hffff;
		return msk[c] ? v : 32'h0;
	endfunction
	// poll status until results are flagged ready
	task automatic waitReady;
		int k;
		k = 0;
		rdv = 32'h0;
		while (rdv[0] !== 1'b1 && k < 5000) begin
			apb(1'b0, OFF_STATUS, 32'h0);
			k++;
		end
		if (k >= 5000) mismatches++;
	endtask
	// read all eighteen result words and compare
	task automatic checkAll(input int m, input int p);
		for (int s = 0; s < NSENS; s++) begin
			for (int c = 0; c < NCH; c++) begin
				apb(1'b0, 8'(OFF_DATA0 + 4 * (s * 6 + c)), 32'h0);
				chk(rdv, expv(s, c, m, p));
			end
		end
	endtask
	// cycles from a prompt result read to the next alert
	task automatic measure;
		n = 0;
		while (intAlert_b !== 1'b0 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		apb(1'b0, OFF_DATA0, 32'h0);
		repeat (3) @(posedge ref_clk);
		n = 3;
		while (intAlert_b !== 1'b0 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	// ============================================================
	// main sequence
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		samplesChecked = 0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, OFF_PERIOD, 32'h0);
		chk(rdv, 32'h0004_45c0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({rdv[30:0], erv}, 32'h1);
		apb(1'b1, OFF_STATUS, 32'hff);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdv, 32'h0);
		// new mode and period settings mid cycle must wait for the cycle end
		apb(1'b1, OFF_PERIOD, 32'd200);
		apb(1'b1, OFF_CTRL, 32'h1);
		waitReady();
		chk(32'(intAlert_b), 32'h1);
		checkAll(0, 40);
		waitReady();
		checkAll(1, 200);
		apb(1'b1, OFF_CTRL, 32'h6);
		waitReady();
		apb(1'b0, OFF_DATA0, 32'h0);
		waitReady();
		chk(32'(intAlert_b), 32'h0);
		checkAll(2, 200);
		repeat (2) @(posedge ref_clk);
		chk(32'(intAlert_b), 32'h1);
		measure();
		chk(32'(n >= 392 && n <= 401), 32'h1);
		// too short a period runs at the minimum
		apb(1'b1, OFF_CTRL, 32'h4);
		apb(1'b1, OFF_PERIOD, 32'd5);
		measure();
		measure();
		measure();
		chk(32'(n >= 32 && n <= 41), 32'h1);
		// long period drives every count in the mode 0 bank to full scale
		apb(1'b1, OFF_PERIOD, 32'd4100);
		apb(1'b0, OFF_DATA0, 32'h0);
		waitReady();
		apb(1'b0, OFF_DATA0, 32'h0);
		waitReady();
		checkAll(0, 4100);
		stop_test();
	end
	// ============================================================
	// watchdog
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		stop_test();
	end
endmodule // spbc_top_test
`default_nettype wire
